// *** hw/capc_delay_line.sv ***
// Shift line that holds captured commands for the parity latency.
// Assumes the tap index is the latency less two and that flush drops every held command.
`include "capc_cfg.svh"
module capc_delay_line
	import capc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        flush_in,
	input  wire logic        push_in,
	input  capc_frame_t      push_frm_in,
	input  wire logic [2:0]  tap_in,
	output logic             tap_vld_out,
	output capc_frame_t      tap_frm_out
);

	capc_dly_st_t st_q;
	capc_dly_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.vld[0] = push_in && !flush_in;
		st_d.frm[0] = push_frm_in;
		for (int i = 1; i < `CAPC_DLY_STAGES; i++) begin
			st_d.vld[i] = st_q.vld[i-1] && !flush_in;
			st_d.frm[i] = st_q.frm[i-1];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tap_vld_out = st_q.vld[tap_in];
	assign tap_frm_out = st_q.frm[tap_in];

endmodule

// *** hw/capc_log_mem.sv ***
// Error log of the multipurpose_readout_page: one word written at once, read a byte at a time.
// Assumes the writer presents the whole log word in the cycle of its write strobe.
module capc_log_mem
	import capc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        wr_in,
	input  wire logic [31:0] wr_word_in,
	input  wire logic [1:0]  sel_in,
	output logic      [7:0]  rd_out
);

	capc_log_st_t st_q;
	capc_log_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (wr_in) begin
			st_d.mem = wr_word_in;
		end
		st_d.rd = st_q.mem[sel_in];
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_out = st_q.rd;

endmodule

// *** hw/capc_parity_checker.sv ***
// Command/address parity checker of the memory device: latency hold, check, alert and log.
// Assumes command pins and mode register writes are synchronous to clk_in.
//
// Operation
// - Even parity over covered pins plus parity bit.
// - Cover command, address, bank, group, chip-id pins.
// - Unused or unconnected pins count as zero.
// - Checking only while the DLL runs.
// - Three-bit latency code; zero disables checking.
// - Hold every selected command for latency.
// - Read and write latency grow by latency.
// - Erroneous command never executes.
// - Dropped reads produce no data strobes.
// - Parity error clears write CRC status; here only while write CRC is enabled.
// - Log offending command and address bits.
// - Status bit set before alert release.
// - Drive alert low soon after error.
// - Wait tRAS, precharge all, execute nothing.
// - Release alert after minimum width, precharged.
// - Accept commands after maximum width, checking off unless in persistent mode.
// - Log keeps first error until cleared; in persistent mode each new error overwrites it.
// - Status accepts only zero writes from controller.
// - Persistent mode resumes checking after alert.
`include "capc_cfg.svh"
module capc_parity_checker
	import capc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        dll_on_in,
	input  wire logic        cs_n_in,
	input  wire logic        act_n_in,
	input  wire logic [16:0] addr_in,
	input  wire logic        a17_in,
	input  wire logic [1:0]  bg_in,
	input  wire logic [1:0]  ba_in,
	input  wire logic [2:0]  cid_in,
	input  wire logic        par_in,
	input  wire logic        a17_used_in,
	input  wire logic        cid_used_in,
	input  wire logic        mr_wr_in,
	input  wire logic [2:0]  mr_pl_in,
	input  wire logic        mr_persist_in,
	input  wire logic        mr_crc_en_in,
	input  wire logic        mr_par_status_in,
	input  wire logic        mr_crc_status_in,
	input  wire logic        crc_err_in,
	input  wire logic [1:0]  log_sel_in,
	output logic             cmd_vld_out,
	output logic             cmd_act_n_out,
	output logic      [16:0] cmd_addr_out,
	output logic             cmd_a17_out,
	output logic      [1:0]  cmd_bg_out,
	output logic      [1:0]  cmd_ba_out,
	output logic      [2:0]  cmd_cid_out,
	output logic             alert_n_out,
	output logic             par_status_out,
	output logic             crc_status_out,
	output logic             precharge_all_out,
	output logic             checking_out,
	output logic      [3:0]  extra_latency_out,
	output logic      [7:0]  log_data_out
);

	// ------------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------------

	// Reserved codes map to no latency, so a stray code never stalls commands.
	function automatic logic [3:0] capc_pl_clocks(input logic [2:0] code);
		logic [3:0] clk_cnt;
		clk_cnt = `CAPC_PL_NONE;
		case (code)
			`CAPC_PL_CODE4: clk_cnt = `CAPC_PL_CLK4;
			`CAPC_PL_CODE5: clk_cnt = `CAPC_PL_CLK5;
			`CAPC_PL_CODE6: clk_cnt = `CAPC_PL_CLK6;
			`CAPC_PL_CODE8: clk_cnt = `CAPC_PL_CLK8;
			default:        clk_cnt = `CAPC_PL_NONE;
		endcase
		return clk_cnt;
	endfunction

	// An odd count of ones over frame and parity bit is an error.
	function automatic logic capc_odd(input capc_frame_t frm, input logic par);
		return ^{frm, par};
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	capc_top_st_t st_q;
	capc_top_st_t st_d;

	capc_frame_t  pin_frm;
	logic         err;
	logic         accept;
	logic         flush;
	logic         push;
	logic [2:0]   tap;
	logic         tap_vld;
	capc_frame_t  tap_frm;
	logic [7:0]   log_rd;

	// ------------------------------------------------------------------------
	// Pin frame
	// ------------------------------------------------------------------------
	// Chip select, clock enable and termination control are not part of the frame.
	always_comb begin
		pin_frm       = '0;
		pin_frm.act_n = act_n_in;
		pin_frm.addr  = addr_in;
		pin_frm.bg    = bg_in;
		pin_frm.ba    = ba_in;
		pin_frm.a17   = a17_in & a17_used_in;
		pin_frm.cid   = cid_in & {3{cid_used_in}};
	end

	// ------------------------------------------------------------------------
	// Held commands
	// ------------------------------------------------------------------------
	// The captured stage already adds one cycle and the output register one more,
	// so the tap sits two stages short of the latency.
	assign tap = 3'(st_q.lat - 4'h2);

	capc_delay_line u_delay (
		.clk_in      (clk_in),
		.rstn_in     (rstn_in),
		.flush_in    (flush),
		.push_in     (push),
		.push_frm_in (st_q.cap_frm),
		.tap_in      (tap),
		.tap_vld_out (tap_vld),
		.tap_frm_out (tap_frm)
	);

	// ------------------------------------------------------------------------
	// Error log
	// ------------------------------------------------------------------------
	capc_log_mem u_log (
		.clk_in     (clk_in),
		.rstn_in    (rstn_in),
		.wr_in      (st_q.log_wr),
		.wr_word_in (st_q.log_word),
		.sel_in     (log_sel_in),
		.rd_out     (log_rd)
	);

	// ------------------------------------------------------------------------
	// Check and accept
	// ------------------------------------------------------------------------
	// The check looks at the captured frame and the parity bit caught with it.
	assign err = st_q.cap_vld && st_q.chk && capc_odd(st_q.cap_frm, st_q.cap_par);

	// Nothing is taken while an error is being worked off.
	assign accept = st_q.cap_vld && !err && (st_q.mode == CAPC_RUN);

	// Commands still held when an error shows up lie in the unknown window and
	// are dropped, so a dropped read never reaches the strobe logic.
	assign flush = err || mr_wr_in;

	assign push = accept && (st_q.lat != `CAPC_PL_NONE);

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		st_d        = st_q;
		st_d.prech  = 1'b0;
		st_d.log_wr = 1'b0;

		st_d.cap_vld = !cs_n_in;
		st_d.cap_frm = pin_frm;
		st_d.cap_par = par_in;

		// Mode register write. A latency move between two non-zero codes is kept
		// out, since the controller is to pass through the disabled code first.
		if (mr_wr_in) begin
			if (mr_pl_in == `CAPC_PL_OFF || st_q.pl_code == `CAPC_PL_OFF) begin
				st_d.pl_code = mr_pl_in;
			end
			st_d.persist = mr_persist_in;
			st_d.crc_en  = mr_crc_en_in;
			// Only a zero is taken; a one is blocked.
			if (!mr_par_status_in) begin
				st_d.par_status = 1'b0;
			end
			if (!mr_crc_status_in) begin
				st_d.crc_status = 1'b0;
			end
		end

		// A write CRC event beats a software clear in the same cycle.
		if (crc_err_in) begin
			st_d.crc_status = 1'b1;
		end

		// Executed command leaves on the latency tap, or straight away when off.
		if (st_q.lat == `CAPC_PL_NONE) begin
			st_d.out_vld = accept;
			st_d.out_frm = st_q.cap_frm;
		end else begin
			st_d.out_vld = tap_vld && !flush;
			st_d.out_frm = tap_frm;
		end

		// Error recovery sequence.
		st_d.cnt = st_q.cnt + `CAPC_CNT_W'(1);
		case (st_q.mode)
			CAPC_RUN: begin
				st_d.cnt = '0;
			end
			CAPC_DRAIN: begin
				if (st_q.cnt == `CAPC_CNT_W'(`CAPC_TRAS_CYC - 1)) begin
					st_d.prech = 1'b1;
					st_d.mode  = CAPC_ALERT;
				end
			end
			CAPC_ALERT: begin
				if (st_q.cnt >= `CAPC_CNT_W'(`CAPC_PW_MIN_CYC - 1)) begin
					st_d.alert_n = 1'b1;
					st_d.mode    = CAPC_QUIET;
				end
			end
			CAPC_QUIET: begin
				if (st_q.cnt >= `CAPC_CNT_W'(`CAPC_PW_MAX_CYC - 1)) begin
					st_d.mode = CAPC_RUN;
				end
			end
			default: begin
				st_d.mode    = CAPC_RUN;
				st_d.alert_n = 1'b1;
			end
		endcase

		// A detected error beats every clear of the same cycle. Each new error
		// overwrites the log, so in persistent mode a second one before clearing replaces the first.
		if (err) begin
			st_d.par_status = 1'b1;
			st_d.alert_n    = 1'b0;
			st_d.mode       = CAPC_DRAIN;
			st_d.cnt        = '0;
			st_d.log_wr     = 1'b1;
			st_d.log_word   = {5'h00, st_q.cap_par, st_q.cap_frm};
			if (st_q.crc_en) begin
				st_d.crc_status = 1'b0;
			end
		end

		st_d.lat = capc_pl_clocks(st_d.pl_code);

		// Checking needs a latency, a running DLL and either a clear status bit
		// or persistent mode; persistent mode waits for the mode to return to CAPC_RUN after the error.
		st_d.chk = (st_d.lat != `CAPC_PL_NONE) && dll_on_in &&
			(!st_d.par_status || st_d.persist) &&
			(st_d.mode == CAPC_RUN);
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q            <= '0;
			st_q.mode       <= CAPC_RUN;
			st_q.alert_n    <= `CAPC_RST_ALERT_N;
			st_q.par_status <= `CAPC_RST_STATUS;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	// The extra latency is added by the read and write timing logic downstream.
	assign cmd_vld_out       = st_q.out_vld;
	assign cmd_act_n_out     = st_q.out_frm.act_n;
	assign cmd_addr_out      = st_q.out_frm.addr;
	assign cmd_a17_out       = st_q.out_frm.a17;
	assign cmd_bg_out        = st_q.out_frm.bg;
	assign cmd_ba_out        = st_q.out_frm.ba;
	assign cmd_cid_out       = st_q.out_frm.cid;
	assign alert_n_out       = st_q.alert_n;
	assign par_status_out    = st_q.par_status;
	assign crc_status_out    = st_q.crc_status;
	assign precharge_all_out = st_q.prech;
	assign checking_out      = st_q.chk;
	assign extra_latency_out = st_q.lat;
	assign log_data_out      = log_rd;

endmodule

// *** shared/capc_cfg.svh ***
// Constants of the command/address parity checker: latency codes, time figures and cycle counts.
// Assumes a single 10 MHz clock; the cycle counts of the protocol times are derived from the figures in ns.
`ifndef CAPC_CFG_SVH
`define CAPC_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and protocol times
// ----------------------------------------------------------------------------
`define CAPC_CLK_NS        100
`define CAPC_ALERT_ON_NS   1000
`define CAPC_PW_MIN_NS     2000
`define CAPC_PW_MAX_NS     4000
`define CAPC_TRAS_MIN_NS   1500

// Least times round up, longest times round down.
`define CAPC_ALERT_ON_CYC  (`CAPC_ALERT_ON_NS / `CAPC_CLK_NS)
`define CAPC_PW_MIN_CYC    ((`CAPC_PW_MIN_NS + `CAPC_CLK_NS - 1) / `CAPC_CLK_NS)
`define CAPC_PW_MAX_CYC    (`CAPC_PW_MAX_NS / `CAPC_CLK_NS)
`define CAPC_TRAS_CYC      ((`CAPC_TRAS_MIN_NS + `CAPC_CLK_NS - 1) / `CAPC_CLK_NS)

// ----------------------------------------------------------------------------
// Parity latency field of mode_register_five
// ----------------------------------------------------------------------------
`define CAPC_PL_OFF        3'h0
`define CAPC_PL_CODE4      3'h1
`define CAPC_PL_CODE5      3'h2
`define CAPC_PL_CODE6      3'h3
`define CAPC_PL_CODE8      3'h4
`define CAPC_PL_CLK4       4'h4
`define CAPC_PL_CLK5       4'h5
`define CAPC_PL_CLK6       4'h6
`define CAPC_PL_CLK8       4'h8
`define CAPC_PL_NONE       4'h0

// ----------------------------------------------------------------------------
// Structure and reset values
// ----------------------------------------------------------------------------
`define CAPC_DLY_STAGES    7
`define CAPC_LOG_BYTES     4
`define CAPC_CNT_W         8
`define CAPC_RST_STATUS    1'b0
`define CAPC_RST_ALERT_N   1'b1

`endif

// *** shared/capc_pkg.sv ***
// Types shared by the parity checker and its delay line and error log.
// Assumes capc_cfg.svh is on the include path.
`include "capc_cfg.svh"

package capc_pkg;

	typedef struct packed {
		logic [2:0]  cid;
		logic        act_n;
		logic [1:0]  bg;
		logic [1:0]  ba;
		logic        a17;
		logic [16:0] addr;
	} capc_frame_t;

	typedef enum logic [3:0] {
		CAPC_RUN   = 4'b0001,
		CAPC_DRAIN = 4'b0010,
		CAPC_ALERT = 4'b0100,
		CAPC_QUIET = 4'b1000
	} capc_mode_t;

	typedef struct packed {
		logic        [`CAPC_DLY_STAGES-1:0] vld;
		capc_frame_t [`CAPC_DLY_STAGES-1:0] frm;
	} capc_dly_st_t;

	typedef struct packed {
		logic [`CAPC_LOG_BYTES-1:0][7:0] mem;
		logic [7:0]                      rd;
	} capc_log_st_t;

	typedef struct packed {
		logic                  cap_vld;
		logic                  cap_par;
		capc_frame_t           cap_frm;
		capc_mode_t            mode;
		logic [`CAPC_CNT_W-1:0] cnt;
		logic [2:0]            pl_code;
		logic [3:0]            lat;
		logic                  persist;
		logic                  crc_en;
		logic                  chk;
		logic                  par_status;
		logic                  crc_status;
		logic                  alert_n;
		logic                  prech;
		logic                  out_vld;
		capc_frame_t           out_frm;
		logic                  log_wr;
		logic [31:0]           log_word;
	} capc_top_st_t;

endpackage

// *** verification/capc_ctrl_model.sv ***
// Controller model driving the command/address pins of the parity checker.
// Assumes requests are latched on the rising edge; pins move on the falling edge.
module capc_ctrl_model
	import capc_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        go_in,
	input  wire logic        bad_in,
	input  wire logic [31:0] rnd_in,
	input  wire logic        a17_used_in,
	input  wire logic        cid_used_in,
	input  wire logic        alert_n_in,
	output logic             cs_n_out,
	output logic             act_n_out,
	output logic      [16:0] addr_out,
	output logic             a17_out,
	output logic      [1:0]  bg_out,
	output logic      [1:0]  ba_out,
	output logic      [2:0]  cid_out,
	output logic             par_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        req_q = 1'b0;
	logic        bad_q = 1'b0;
	capc_frame_t frm;

	initial {cs_n_out, act_n_out, addr_out, a17_out, bg_out, ba_out, cid_out, par_out} = 28'h8000000;

	// Unconnected pins carry no weight, since the device reads them as zero.
	always_comb begin
		frm = rnd_in[25:0];
		frm.a17 = rnd_in[17] & a17_used_in;
		frm.cid = rnd_in[25:23] & {3{cid_used_in}};
	end

	always @(posedge clk_in) begin
		req_q <= go_in;
		bad_q <= bad_in;
	end

	// Between commands the pins toggle, so a device sampling them then sees noise.
	always @(negedge clk_in) begin
		if (req_q && alert_n_in) begin
			cs_n_out <= 1'b0;
			{cid_out, act_n_out, bg_out, ba_out, a17_out, addr_out} <= rnd_in[25:0];
			par_out <= ^frm ^ bad_q;
		end else begin
			cs_n_out <= 1'b1;
			{act_n_out, addr_out, a17_out, bg_out, ba_out, cid_out, par_out} <=
				~{act_n_out, addr_out, a17_out, bg_out, ba_out, cid_out, par_out};
		end
	end
endmodule

// *** verification/capc_parity_checker_monitor.sv ***
// Port checker of the parity checker: alert timing, latency hold and gating.
// Assumes one clock domain; bound to the top module by the bench.
module capc_parity_checker_monitor (
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        dll_on_in,
	input wire logic        cs_n_in,
	input wire logic        act_n_in,
	input wire logic [16:0] addr_in,
	input wire logic        a17_in,
	input wire logic [1:0]  bg_in,
	input wire logic [1:0]  ba_in,
	input wire logic [2:0]  cid_in,
	input wire logic        par_in,
	input wire logic        a17_used_in,
	input wire logic        cid_used_in,
	input wire logic        cmd_vld_out,
	input wire logic [16:0] cmd_addr_out,
	input wire logic        alert_n_out,
	input wire logic        par_status_out,
	input wire logic        precharge_all_out,
	input wire logic        checking_out,
	input wire logic [3:0]  extra_latency_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	property odd_frame_p;
		!cs_n_in && checking_out && alert_n_out && (^{act_n_in, addr_in, a17_in & a17_used_in,
			bg_in, ba_in, cid_in & {3{cid_used_in}}, par_in}) |-> ##2 !alert_n_out;
	endproperty
	odd_alert_a: assert property (odd_frame_p)
		else $error("odd frame without alert");
	status_set_a: assert property ($fell(alert_n_out) |-> par_status_out)
		else $error("alert without status");
	alert_width_a: assert property ($fell(alert_n_out) |-> ##19 !alert_n_out)
		else $error("alert too short");
	alert_quiet_a: assert property (
		$fell(alert_n_out) |-> !cmd_vld_out throughout (##20 alert_n_out))
		else $error("command during alert or alert too long");
	prech_time_a: assert property ($fell(alert_n_out) |-> ##15 precharge_all_out)
		else $error("precharge not at tRAS");
	prech_alert_a: assert property (
		precharge_all_out |-> !alert_n_out && $past(alert_n_out, 8) == 1'b0)
		else $error("precharge outside alert");
	dll_gate_a: assert property (!dll_on_in |=> !checking_out)
		else $error("checking without dll");
	lat_code_a: assert property (
		checking_out |-> extra_latency_out inside {4'h4, 4'h5, 4'h6, 4'h8})
		else $error("bad latency while checking");
	lat_hold_a: assert property (
		cmd_vld_out && extra_latency_out == 4'h4
		|-> !$past(cs_n_in, 5) && cmd_addr_out == $past(addr_in, 5))
		else $error("command not held four clocks");
	status_rise_a: assert property ($rose(par_status_out) |-> $fell(alert_n_out))
		else $error("status set without error");

	cover property ($fell(alert_n_out));
	cover property (cmd_vld_out && extra_latency_out == 4'h8);
	cover property (checking_out && par_status_out);
endmodule

// *** verification/tb.sv ***
// Self-checking bench of the parity checker with a controller model on its pins.
// Assumes the recovery timing of the hand-over: alert 20 cycles, run again after 40.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Signals
	// ----
	logic clk_in = 1'b0, rstn_in = 1'b0, dll_on_in = 1'b1, mr_wr_in = 1'b0;
	logic mr_persist_in = 1'b0, mr_crc_en_in = 1'b0, mr_par_status_in = 1'b0;
	logic mr_crc_status_in = 1'b0, crc_err_in = 1'b0, go = 1'b0, bad = 1'b0;
	logic a17_used_in = 1'b1, cid_used_in = 1'b1;
	logic [2:0] mr_pl_in = 3'h0;
	logic [1:0] log_sel_in = 2'h0;
	logic [31:0] rnd = 32'h0000590C;
	logic cs_n_in, act_n_in, a17_in, par_in, cmd_vld_out, cmd_act_n_out, cmd_a17_out;
	logic alert_n_out, par_status_out, crc_status_out, precharge_all_out, checking_out;
	logic [16:0] addr_in, cmd_addr_out;
	logic [1:0] bg_in, ba_in, cmd_bg_out, cmd_ba_out;
	logic [2:0] cid_in, cmd_cid_out;
	logic [3:0] extra_latency_out;
	logic [7:0] log_data_out;
	logic [26:0] fr;
	logic [25:0] cmd_frm;
	int miscompares = 0, n_compared = 0;

	assign cmd_frm = {cmd_cid_out, cmd_act_n_out, cmd_bg_out, cmd_ba_out, cmd_a17_out, cmd_addr_out};
	always #50 clk_in = ~clk_in;

	capc_parity_checker dut (.clk_in, .rstn_in, .dll_on_in, .cs_n_in, .act_n_in, .addr_in,
		.a17_in, .bg_in, .ba_in, .cid_in, .par_in, .a17_used_in, .cid_used_in, .mr_wr_in,
		.mr_pl_in, .mr_persist_in, .mr_crc_en_in, .mr_par_status_in, .mr_crc_status_in,
		.crc_err_in, .log_sel_in, .cmd_vld_out, .cmd_act_n_out, .cmd_addr_out, .cmd_a17_out,
		.cmd_bg_out, .cmd_ba_out, .cmd_cid_out, .alert_n_out, .par_status_out,
		.crc_status_out, .precharge_all_out, .checking_out, .extra_latency_out, .log_data_out);
	capc_ctrl_model ctl (.clk_in, .go_in(go), .bad_in(bad), .rnd_in(rnd), .a17_used_in,
		.cid_used_in, .alert_n_in(alert_n_out), .cs_n_out(cs_n_in), .act_n_out(act_n_in),
		.addr_out(addr_in), .a17_out(a17_in), .bg_out(bg_in), .ba_out(ba_in),
		.cid_out(cid_in), .par_out(par_in));

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [3:0] lat(input logic [2:0] c);
		return (c == 3'h1) ? 4'h4 : (c == 3'h2) ? 4'h5 : (c == 3'h3) ? 4'h6 :
			(c == 3'h4) ? 4'h8 : 4'h0;
	endfunction
	function automatic logic [3:0] cy(input logic [2:0] c);
		return (lat(c) == 4'h0) ? 4'h1 : lat(c);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic mrw(input logic [2:0] pl, input logic ps, input logic ce);
		@(negedge clk_in);
		{mr_wr_in, mr_pl_in, mr_persist_in, mr_crc_en_in} = {1'b1, pl, ps, ce};
		@(negedge clk_in);
		mr_wr_in = 1'b0;
		@(negedge clk_in);
	endtask
	task automatic cmd(input logic e, input logic b, input logic [3:0] n);
		int i;
		@(negedge clk_in);
		rnd = lfsr(rnd);
		{go, bad, a17_used_in, cid_used_in} = {1'b1, b, rnd[27:26]};
		@(negedge clk_in);
		go = 1'b0;
		@(posedge clk_in);
		fr = {par_in, cid_in & {3{cid_used_in}}, act_n_in, bg_in, ba_in, a17_in & a17_used_in, addr_in};
		i = 0;
		do begin
			@(posedge clk_in);
			#1;
			i++;
		end while (i < 60 && cmd_vld_out !== 1'b1 && alert_n_out !== 1'b0);
		if (i >= 60) begin
			miscompares++;
			final_report();
		end
		chk(32'(i), e ? 32'h1 : 32'(n));
		chk(alert_n_out, !e);
		if (e) chk(par_status_out, 1'b1);
		else chk(cmd_frm, fr[25:0]);
		@(negedge clk_in);
	endtask
	task automatic log_chk(input logic [31:0] w);
		int k;
		for (k = 0; k < 4; k++) begin
			@(negedge clk_in);
			log_sel_in = k[1:0];
			@(posedge clk_in);
			#1;
			chk(log_data_out, w[8*k +: 8]);
		end
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		int c;
		logic b;
		logic [31:0] w;
		repeat (16) @(negedge clk_in);
		rstn_in = 1'b1;
		@(posedge clk_in);
		#1;
		chk({alert_n_out, par_status_out, checking_out, extra_latency_out}, 32'h40);
		for (c = 0; c < 8; c++) begin
			mrw(3'h0, 1'b0, 1'b0);
			mrw(c[2:0], 1'b0, 1'b0);
			chk(extra_latency_out, lat(c[2:0]));
			chk(checking_out, lat(c[2:0]) != 4'h0);
			repeat (3) cmd(1'b0, 1'b0, cy(c[2:0]));
		end
		mrw(3'h0, 1'b0, 1'b0);
		mrw(3'h1, 1'b0, 1'b0);
		mrw(3'h3, 1'b0, 1'b0);
		chk(extra_latency_out, 4'h4);
		dll_on_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk(checking_out, 1'b0);
		cmd(1'b0, 1'b1, 4'h4);
		dll_on_in = 1'b1;
		mrw(3'h0, 1'b0, 1'b0);
		mrw(3'h2, 1'b0, 1'b1);
		crc_err_in = 1'b1;
		@(negedge clk_in);
		crc_err_in = 1'b0;
		@(negedge clk_in);
		chk(crc_status_out, 1'b1);
		cmd(1'b1, 1'b1, 4'h5);
		chk(crc_status_out, 1'b0);
		w = {5'h00, fr};
		log_chk(w);
		repeat (40) @(negedge clk_in);
		chk(checking_out, 1'b0);
		cmd(1'b0, 1'b1, 4'h5);
		log_chk(w);
		mrw(3'h2, 1'b0, 1'b1);
		chk({par_status_out, checking_out}, 2'b01);
		mr_par_status_in = 1'b1;
		mrw(3'h2, 1'b0, 1'b1);
		mr_par_status_in = 1'b0;
		chk(par_status_out, 1'b0);
		mrw(3'h0, 1'b0, 1'b0);
		mrw(3'h4, 1'b1, 1'b0);
		for (c = 0; c < 24; c++) begin
			rnd = lfsr(rnd);
			b = rnd[29] || c < 2;
			cmd(b, b, 4'h8);
			if (b) begin
				log_chk({5'h00, fr});
				repeat (40) @(negedge clk_in);
				chk({par_status_out, checking_out}, 2'b11);
			end
		end
		// A good command still held in the latency line is dropped by the error behind it.
		@(negedge clk_in);
		{go, bad} = 2'b10;
		@(negedge clk_in);
		bad = 1'b1;
		@(negedge clk_in);
		{go, bad} = 2'b00;
		c = 0;
		w = 32'h0;
		repeat (45) begin
			@(posedge clk_in);
			#1;
			if (cmd_vld_out !== 1'b0) c++;
			if (alert_n_out === 1'b0) w = w + 32'h1;
		end
		chk(32'(c), 32'h0);
		chk(w, 32'h14);
		// Stand-ins for the extra refreshes a careful controller sends after an error.
		repeat (2) cmd(1'b0, 1'b0, 4'h8);
		final_report();
	end
endmodule

bind capc_parity_checker capc_parity_checker_monitor mon (.clk_in, .rstn_in, .dll_on_in,
	.cs_n_in, .act_n_in, .addr_in, .a17_in, .bg_in, .ba_in, .cid_in, .par_in, .a17_used_in,
	.cid_used_in, .cmd_vld_out, .cmd_addr_out, .alert_n_out, .par_status_out,
	.precharge_all_out, .checking_out, .extra_latency_out);
